// *** verilog/tdfa_pkg.sv ***
package tdfa_pkg;

  // ****************************************************************
  // multiplex frame layout (34 368 kbit/s side)
  // ****************************************************************
  localparam int          MUX_SLOTS        = 4;
  localparam int          MUX_SETS         = 4;
  localparam logic [8:0]  MUX_SET_LAST     = 9'h17f;  // 384 bits per set
  localparam logic [8:0]  MUX_OVH_BITS     = 9'h00c;  // set 1 overhead
  localparam logic [8:0]  MUX_CBIT_END     = 9'h004;  // sets 2..4 control bits
  localparam logic [8:0]  MUX_JBIT_END     = 9'h008;  // set 4 opportunity bits
  localparam logic [1:0]  MUX_SET_FIRST    = 2'h0;
  localparam logic [1:0]  MUX_SET_JUST     = 2'h3;
  localparam logic [1:0]  CBIT_MAJORITY    = 2'h2;

  // ****************************************************************
  // tributary frame layout (8 448 kbit/s side)
  // ****************************************************************
  localparam logic [9:0]  TRIB_FRAME_LAST  = 10'h34f;  // 848 bits per frame
  localparam int          FAW_LEN          = 10;
  localparam logic [9:0]  FAW_PATTERN      = 10'h3d0;  // 1111010000
  localparam logic [9:0]  FAW_LAST_POS     = 10'h009;
  localparam logic [9:0]  RDI_POS          = 10'h00a;
  localparam logic [9:0]  NU_POS           = 10'h00b;
  localparam logic [2:0]  LOSS_MISSES      = 3'h4;
  localparam logic [1:0]  ALIGN_HITS       = 2'h3;

  // ****************************************************************
  // all-ones detection
  // ****************************************************************
  localparam logic [2:0]  AIS_RUNS         = 3'h4;
  localparam logic [9:0]  AIS_INTV_LAST    = 10'h34f;  // 848 bits
  localparam logic [2:0]  AIS_ZEROS        = 3'h5;

  // ****************************************************************
  // read clock synthesis
  // ****************************************************************
  localparam longint      REF_CLK_HZ       = 64'h17d7840;  // 25 MHz
  localparam longint      TRIB_RATE_HZ     = 64'h80e800;   // 8 448 kHz
  localparam int          NCO_BITS         = 24;
  localparam longint      NCO_INC_NOM_L    = (TRIB_RATE_HZ * (64'h1 << NCO_BITS)) / REF_CLK_HZ;
  localparam logic [27:0] NCO_INC_NOM      = NCO_INC_NOM_L[27:0];

  typedef enum logic [1:0] {
    TDFA_HUNT,
    TDFA_CONFIRM,
    TDFA_SYNC
  } tdfa_align_e;

endpackage : tdfa_pkg

// *** verilog/tdfa_bit_store.sv ***
`timescale 1ns/10ps

module tdfa_bit_store #(
  parameter int WIDTH     = 1,
  parameter int ADDR_BITS = 6
) (
  // clock
  input  wire logic                 ref_clk_in,
  // write port
  input  wire logic                 wr_en_in,
  input  wire logic [ADDR_BITS-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]     wr_data_in,
  // read port
  input  wire logic                 rd_en_in,
  input  wire logic [ADDR_BITS-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]     rd_data_out
);

  logic [WIDTH-1:0] mem_r [0:(1<<ADDR_BITS)-1];

  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in) begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end

endmodule : tdfa_bit_store

// *** verilog/tdfa_demapper.sv ***
`timescale 1ns/10ps
// How it works
// [R01] vote the three control bits; majority one discards the opportunity bit
// [R02] write recovered bits gapped, read them on an evenly spaced synthesized clock
// [R03] store depth absorbs tolerance and jitter without bit errors
// [R04] fill-driven rate loop recovers from frequency steps in bounded time
// [R05] module parameter picks one of four interleaved tributary slots
// [R06] inactive function sends all-ones and silences reports
// [R07] aligned: four consecutive wrong words at expected place lose alignment
// [R08] unaligned: three consecutive words at one position regain alignment
// [R09] candidate dropped if word missing in either of next two frames
// [R10] frame loss defect sets on four misses, clears on three hits
// [R11] all-ones defect: four 848-bit intervals with fewer than five zeros
// [R12] either defect raises server fail and forces all-ones output at once
// [R13] all-ones report needs defect, no trail fail, and report enable
// [R14] frame loss report needs frame loss defect without all-ones defect
// [R15] frame start marker pulses with first bit of each recovered frame
// [R16] frame is 848 bits, first twelve are word, remote defect, national
// [R17] national-use bit passes through uninterpreted
// [R18] expected alignment word is 1111010000
// [R19] read rate follows store fill through a phase accumulator
module tdfa_demapper
  import tdfa_pkg::*;
#(
  parameter int          TRIB_SLOT  = 1,
  parameter int          ADDR_BITS  = 6,
  parameter logic [27:0] NCO_GAIN   = NCO_INC_NOM >> ADDR_BITS
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  // multiplex side
  input  wire logic mux_clk_in,
  input  wire logic mux_data_in,
  input  wire logic mux_frame_start_in,
  input  wire logic incoming_trail_fail_in,
  // management
  input  wire logic function_active_in,
  input  wire logic all_ones_report_enable_in,
  output logic      frame_loss_report_out,
  output logic      all_ones_report_out,
  // tributary side
  output logic      tributary_clk_out,
  output logic      tributary_data_out,
  output logic      tributary_frame_start_out,
  output logic      server_signal_fail_out,
  output logic      remote_defect_bit_out,
  output logic      national_use_bit_out
);

  localparam logic [1:0]         SLOT_IDX   = 2'(TRIB_SLOT - 1);
  localparam logic [ADDR_BITS:0] STORE_FULL = (ADDR_BITS+1)'(1 << ADDR_BITS);
  localparam logic [ADDR_BITS:0] STORE_MID  = (ADDR_BITS+1)'(1 << (ADDR_BITS-1));

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] mclk_sync_r;
  logic [1:0] mdat_sync_r;
  logic [1:0] mfs_sync_r;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mclk_sync_r <= 3'h0;
      mdat_sync_r <= 2'h0;
      mfs_sync_r  <= 2'h0;
    end else begin
      mclk_sync_r <= {mclk_sync_r[1:0], mux_clk_in};
      mdat_sync_r <= {mdat_sync_r[0], mux_data_in};
      mfs_sync_r  <= {mfs_sync_r[0], mux_frame_start_in};
    end
  end

  wire mux_edge = mclk_sync_r[1] & ~mclk_sync_r[2];
  wire mux_bit  = mdat_sync_r[1];
  wire mux_fs   = mfs_sync_r[1];

  // ****************************************************************
  // multiplex position and slot extraction
  // ****************************************************************
  logic [1:0] set_r;
  logic [8:0] off_r;
  logic [1:0] cbit_ones_r;

  wire [1:0] bit_set   = mux_fs ? MUX_SET_FIRST : set_r;
  wire [8:0] bit_off   = mux_fs ? 9'h000 : off_r;
  // slots are bit interleaved and every field length is a multiple of four
  wire       is_mine   = (bit_off[1:0] == SLOT_IDX);                            // [R05]
  wire       is_ovh    = (bit_set == MUX_SET_FIRST) && (bit_off < MUX_OVH_BITS);
  wire       is_cbit   = (bit_set != MUX_SET_FIRST) && (bit_off < MUX_CBIT_END);
  wire       is_jbit   = (bit_set == MUX_SET_JUST) && !is_cbit && (bit_off < MUX_JBIT_END);
  wire       j_stuffed = (cbit_ones_r >= CBIT_MAJORITY);                        // [R01]
  wire       take_bit  = mux_edge && is_mine && !is_ovh && !is_cbit
                         && !(is_jbit && j_stuffed);                            // [R01]
  wire       set_wrap  = (bit_off == MUX_SET_LAST);
  wire       frm_first = (bit_set == MUX_SET_FIRST) && (bit_off == 9'h000);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      set_r       <= 2'h0;
      off_r       <= 9'h000;
      cbit_ones_r <= 2'h0;
    end else if (mux_edge) begin
      off_r <= set_wrap ? 9'h000 : bit_off + 9'h001;
      set_r <= set_wrap ? bit_set + 2'h1 : bit_set;
      if (frm_first) begin
        cbit_ones_r <= 2'h0;
      end else if (is_cbit && is_mine && mux_bit) begin
        cbit_ones_r <= cbit_ones_r + 2'h1;                                      // [R01]
      end
    end
  end

  // ****************************************************************
  // elastic store and fill-driven read clock
  // ****************************************************************
  logic [ADDR_BITS:0]  wr_ptr_r;
  logic [ADDR_BITS:0]  rd_ptr_r;
  logic [NCO_BITS:0]   nco_acc_r;
  logic                rd_vld_r;
  logic                store_bit;

  wire [ADDR_BITS:0] fill       = wr_ptr_r - rd_ptr_r;
  wire               store_full = (fill == STORE_FULL);
  wire               store_emp  = (fill == '0);
  // writes are dropped when full rather than corrupting unread bits
  wire               wr_go      = take_bit && !store_full;                      // [R02]
  wire signed [29:0] fill_err   = 30'(signed'({1'b0, fill})) - 30'(signed'({1'b0, STORE_MID}));
  wire signed [29:0] inc_raw    = 30'(signed'({2'b00, NCO_INC_NOM}))
                                  + 30'(fill_err * signed'({2'b00, NCO_GAIN})); // [R19]
  wire [NCO_BITS-1:0] nco_inc   = inc_raw[29] ? '0 : inc_raw[NCO_BITS-1:0];
  wire [NCO_BITS:0]  nco_sum    = {1'b0, nco_acc_r[NCO_BITS-1:0]} + {1'b0, nco_inc};
  // a carry is one evenly spaced read tick; an empty store skips it
  wire               rd_go      = nco_sum[NCO_BITS] && !store_emp;              // [R02] [R04]

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      nco_acc_r <= '0;
      rd_vld_r  <= 1'b0;
    end else begin
      nco_acc_r <= nco_sum;
      rd_vld_r  <= rd_go;
      if (wr_go) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (rd_go) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  tdfa_bit_store #(
    .WIDTH     (1),
    .ADDR_BITS (ADDR_BITS)                                                      // [R03]
  ) u_store (
    .ref_clk_in  (ref_clk_in),
    .wr_en_in    (wr_go),
    .wr_addr_in  (wr_ptr_r[ADDR_BITS-1:0]),
    .wr_data_in  (mux_bit),
    .rd_en_in    (rd_go),
    .rd_addr_in  (rd_ptr_r[ADDR_BITS-1:0]),
    .rd_data_out (store_bit)
  );

  // ****************************************************************
  // frame alignment
  // ****************************************************************
  tdfa_align_e        state_r;
  logic [FAW_LEN-1:0] shift_r;
  logic [9:0]         pos_r;
  logic [1:0]         hits_r;
  logic [2:0]         miss_r;
  logic               lof_r;

  // the output runs one word behind, so the word check lands on bit 0
  wire [FAW_LEN-1:0] shift_nxt = {shift_r[FAW_LEN-2:0], store_bit};
  wire               faw_hit   = (shift_nxt == FAW_PATTERN);                    // [R18]
  wire [9:0]         tpos      = (pos_r == TRIB_FRAME_LAST) ? 10'h000 : pos_r + 10'h001; // [R16]
  wire               at_check  = (tpos == FAW_LAST_POS);
  wire               oldest    = shift_nxt[FAW_LEN-1];

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= TDFA_HUNT;
      shift_r <= '0;
      pos_r   <= 10'h000;
      hits_r  <= 2'h0;
      miss_r  <= 3'h0;
      lof_r   <= 1'b1;
    end else if (rd_vld_r) begin
      shift_r <= shift_nxt;
      pos_r   <= tpos;
      case (state_r)
        TDFA_HUNT: begin
          if (faw_hit) begin
            state_r <= TDFA_CONFIRM;
            pos_r   <= FAW_LAST_POS;
            hits_r  <= 2'h1;
          end
        end
        TDFA_CONFIRM: begin
          if (at_check && !faw_hit) begin
            state_r <= TDFA_HUNT;                                               // [R09]
          end else if (at_check && (hits_r + 2'h1 == ALIGN_HITS)) begin
            state_r <= TDFA_SYNC;                                               // [R08]
            miss_r  <= 3'h0;
            lof_r   <= 1'b0;                                                    // [R10]
          end else if (at_check) begin
            hits_r  <= hits_r + 2'h1;
          end
        end
        TDFA_SYNC: begin
          if (at_check && faw_hit) begin
            miss_r <= 3'h0;
          end else if (at_check && (miss_r + 3'h1 == LOSS_MISSES)) begin
            state_r <= TDFA_HUNT;                                               // [R07]
            lof_r   <= 1'b1;                                                    // [R10]
          end else if (at_check) begin
            miss_r <= miss_r + 3'h1;
          end
        end
        default: begin
          state_r <= TDFA_HUNT;
        end
      endcase
    end
  end

  // ****************************************************************
  // all-ones detection over fixed intervals
  // ****************************************************************
  logic [9:0] intv_r;
  logic [2:0] zeros_r;
  logic [2:0] few_run_r;
  logic [2:0] many_run_r;
  logic       ais_r;

  wire [2:0] zeros_now = (!store_bit && zeros_r != AIS_ZEROS) ? zeros_r + 3'h1 : zeros_r;
  wire       intv_end  = (intv_r == AIS_INTV_LAST);
  wire       few_zeros = (zeros_now < AIS_ZEROS);                               // [R11]

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      intv_r     <= 10'h000;
      zeros_r    <= 3'h0;
      few_run_r  <= 3'h0;
      many_run_r <= 3'h0;
      ais_r      <= 1'b0;
    end else if (rd_vld_r) begin
      intv_r  <= intv_end ? 10'h000 : intv_r + 10'h001;
      zeros_r <= intv_end ? 3'h0 : zeros_now;
      if (intv_end && few_zeros) begin
        many_run_r <= 3'h0;
        few_run_r  <= (few_run_r == AIS_RUNS) ? few_run_r : few_run_r + 3'h1;
        if (few_run_r + 3'h1 >= AIS_RUNS) begin
          ais_r <= 1'b1;                                                        // [R11]
        end
      end else if (intv_end) begin
        few_run_r  <= 3'h0;
        many_run_r <= (many_run_r == AIS_RUNS) ? many_run_r : many_run_r + 3'h1;
        if (many_run_r + 3'h1 >= AIS_RUNS) begin
          ais_r <= 1'b0;                                                        // [R11]
        end
      end
    end
  end

  // ****************************************************************
  // consequent actions, reports and tributary outputs
  // ****************************************************************
  wire server_fail_action      = function_active_in && (ais_r || lof_r);        // [R12]
  wire insert_all_ones_action  = !function_active_in || server_fail_action;     // [R06] [R12]
  wire all_ones_report_nxt     = function_active_in && ais_r && !incoming_trail_fail_in
                                 && all_ones_report_enable_in;                  // [R13] [R06]
  wire frame_loss_report_nxt   = function_active_in && lof_r && !ais_r;         // [R14] [R06]
  wire frame_start_nxt         = at_check && (state_r == TDFA_SYNC);            // [R15]

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tributary_clk_out         <= 1'b0;
      tributary_data_out        <= 1'b1;
      tributary_frame_start_out <= 1'b0;
      server_signal_fail_out    <= 1'b0;
      frame_loss_report_out     <= 1'b0;
      all_ones_report_out       <= 1'b0;
      remote_defect_bit_out     <= 1'b0;
      national_use_bit_out      <= 1'b0;
    end else begin
      tributary_clk_out      <= rd_vld_r;
      server_signal_fail_out <= server_fail_action;
      frame_loss_report_out  <= frame_loss_report_nxt;
      all_ones_report_out    <= all_ones_report_nxt;
      // all-ones takes over at once; strobes may be far apart while the store is empty
      if (rd_vld_r || insert_all_ones_action) begin
        tributary_data_out <= insert_all_ones_action ? 1'b1 : oldest;           // [R12] [R06]
      end
      if (rd_vld_r) begin
        tributary_frame_start_out <= frame_start_nxt;                           // [R15]
        if (tpos == RDI_POS) begin
          remote_defect_bit_out <= store_bit;                                   // [R16]
        end
        if (tpos == NU_POS) begin
          national_use_bit_out  <= store_bit;                                   // [R17]
        end
      end else begin
        tributary_frame_start_out <= 1'b0;
      end
    end
  end

endmodule : tdfa_demapper

// *** bench/tdfa_mux_model.sv ***
`timescale 1ns/10ps
module tdfa_mux_model
  import tdfa_pkg::*;
#(
  parameter int SLOT = 1
) (
  // control
  input  wire logic all_ones_in,
  // multiplex stream
  output logic      mux_clk_out,
  output logic      mux_data_out,
  output logic      mux_frame_start_out
);
  int p  = 0;
  int t  = 0;
  int fr = 0;

  // ****************************************************************
  // tributary source and multiplex framing
  // ****************************************************************
  function automatic logic trib_bit(input int i);
    if (all_ones_in) return 1'b1;
    if (i < FAW_LEN) return FAW_PATTERN[9-i];
    if (i < 12) return i == 11;  // remote bit clear, national bit set
    return i[0];
  endfunction : trib_bit

  // other slots carry zeros so a wrong slot never aligns
  task automatic next_bit;
    int   s;
    int   q;
    logic own;
    logic use_t;
    s = p / 384;
    q = p % 384;
    own = (q % 4) == SLOT - 1;
    use_t = own;
    mux_data_out = 1'b0;
    if (s == 0 && q < 12) begin
      use_t = 1'b0;
      mux_data_out = 1'b1;
    end else if (s > 0 && q < 4) begin
      use_t = 1'b0;
      mux_data_out = own & (fr[0] ^ (s == 1));  // one bit outvoted, odd frames stuff
    end else if (s == 3 && q < 8) begin
      use_t = own & ~fr[0];
    end
    if (use_t) begin
      mux_data_out = trib_bit(t);
      t = (t + 1) % 848;
    end
    mux_frame_start_out = p == 0;
    p = (p + 1) % 1536;
    if (p == 0) fr++;
  endtask : next_bit

  initial begin
    mux_clk_out = 1'b0;
    mux_data_out = 1'b0;
    mux_frame_start_out = 1'b0;
    #7;
    forever begin
      next_bit();
      #160 mux_clk_out = 1'b1;
      #160 mux_clk_out = 1'b0;
    end
  end
endmodule : tdfa_mux_model

// *** bench/tdfa_checker.sv ***
`timescale 1ns/10ps
module tdfa_checker (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // management
  input wire logic incoming_trail_fail_in,
  input wire logic function_active_in,
  input wire logic all_ones_report_enable_in,
  input wire logic frame_loss_report_out,
  input wire logic all_ones_report_out,
  // tributary side
  input wire logic tributary_clk_out,
  input wire logic tributary_data_out,
  input wire logic tributary_frame_start_out,
  input wire logic server_signal_fail_out
);
  logic [9:0] gap_r;
  logic       seen_r;

  // ****************************************************************
  // strobes between frame markers; restarts while failing
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap_r  <= 10'h000;
      seen_r <= 1'b0;
    end else if (tributary_frame_start_out) begin
      gap_r  <= 10'h000;
      seen_r <= 1'b1;
    end else begin
      if (tributary_clk_out) gap_r <= gap_r + 10'h001;
      if (server_signal_fail_out) seen_r <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_INACTIVE_DATA: assert property (
    !function_active_in [*3] |-> tributary_data_out) else $error("data not ones while idle");
  AST_INACTIVE_RPT: assert property (
    !function_active_in [*2] |-> !(frame_loss_report_out || all_ones_report_out))
    else $error("report while idle");
  AST_AIS_GATE: assert property (
    all_ones_report_out |-> $past(all_ones_report_enable_in) && !$past(incoming_trail_fail_in)
    && $past(function_active_in)) else $error("all-ones report not gated");
  AST_RPT_SSF: assert property (
    frame_loss_report_out || all_ones_report_out |-> server_signal_fail_out)
    else $error("report without server fail");
  AST_FL_EXCL: assert property (
    frame_loss_report_out |-> !all_ones_report_out) else $error("both reports");
  AST_FAIL_DATA: assert property (
    server_signal_fail_out && $past(server_signal_fail_out, 3) && tributary_clk_out
    |-> tributary_data_out) else $error("data not ones while failing");
  AST_FS_DATA: assert property (
    tributary_frame_start_out |-> tributary_clk_out && tributary_data_out)
    else $error("frame marker off strobe or bit");
  AST_SPACING: assert property (
    tributary_clk_out |=> !tributary_clk_out) else $error("strobes adjacent");
  AST_FS_PERIOD: assert property (
    tributary_frame_start_out && seen_r |-> gap_r == 10'h34f) else $error("frame length");
endmodule : tdfa_checker

bind tdfa_demapper tdfa_checker u_chk (
  .ref_clk_in,
  .reset_n_in,
  .incoming_trail_fail_in,
  .function_active_in,
  .all_ones_report_enable_in,
  .frame_loss_report_out,
  .all_ones_report_out,
  .tributary_clk_out,
  .tributary_data_out,
  .tributary_frame_start_out,
  .server_signal_fail_out
);

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import tdfa_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic trail = 1'b0;
  logic active = 1'b1;
  logic enable = 1'b1;
  logic ones = 1'b0;
  logic mclk, mdat, mfs, flr, aisr, tclk, tdat, tfs, ssf, remote_defect_bit, nu;
  int   n_fail = 0;
  int   samples_checked = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  tdfa_mux_model #(.SLOT(2)) u_mux (
    .all_ones_in(ones),
    .mux_clk_out(mclk),
    .mux_data_out(mdat),
    .mux_frame_start_out(mfs)
  );

  tdfa_demapper #(.TRIB_SLOT(2)) u_dut (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .mux_clk_in(mclk),
    .mux_data_in(mdat),
    .mux_frame_start_in(mfs),
    .incoming_trail_fail_in(trail),
    .function_active_in(active),
    .all_ones_report_enable_in(enable),
    .frame_loss_report_out(flr),
    .all_ones_report_out(aisr),
    .tributary_clk_out(tclk),
    .tributary_data_out(tdat),
    .tributary_frame_start_out(tfs),
    .server_signal_fail_out(ssf),
    .remote_defect_bit_out(remote_defect_bit),
    .national_use_bit_out(nu)
  );

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // store may run empty, so strobes can gap for a while
  task automatic wait_strobe;
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (tclk !== 1'b1 && n < 2000);
  endtask : wait_strobe

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_align;
    logic [11:0] hdr;
    int          k;
    hdr = 12'h000;
    // outputs keep their reset values until the first edge after release
    repeat (2) @(negedge ref_clk_in);
    check(12'(ssf), 12'h001);
    for (int i = 0; i < 160000 && ssf !== 1'b0; i++) @(negedge ref_clk_in);
    check(12'({ssf, flr}), 12'h000);
    k = 0;
    while (tfs !== 1'b1 && k < 900) begin
      wait_strobe();
      k++;
    end
    for (int i = 0; i < 12; i++) begin
      hdr = {hdr[10:0], tdat};
      if (i < 11) wait_strobe();
    end
    check(hdr, {FAW_PATTERN, 2'b01});
    k = 11;
    do begin
      wait_strobe();
      k++;
    end while (tfs !== 1'b1 && k < 2000);
    check(12'(k), 12'h350);
    check(12'({remote_defect_bit, nu}), 12'h001);
  endtask : t_align

  task automatic t_defect;
    @(posedge ref_clk_in);
    #1 ones = 1'b1;
    for (int i = 0; i < 200000 && aisr !== 1'b1; i++) @(negedge ref_clk_in);
    check(12'({aisr, flr, ssf}), 12'h005);
    wait_strobe();
    wait_strobe();
    check(12'(tdat), 12'h001);
    @(posedge ref_clk_in);
    #1 trail = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check(12'(aisr), 12'h000);
    @(posedge ref_clk_in);
    #1 trail = 1'b0;
    enable = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    check(12'(aisr), 12'h000);
    @(posedge ref_clk_in);
    #1 enable = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check(12'(aisr), 12'h001);
    @(posedge ref_clk_in);
    #1 active = 1'b0;
    repeat (40) @(negedge ref_clk_in);
    check(12'({flr, aisr, ssf, tdat}), 12'h001);
  endtask : t_defect

  initial begin
    repeat (16) @(posedge ref_clk_in);
    #1 reset_n_in = 1'b1;
    t_align();
    t_defect();
    summarize();
  end

  initial begin
    #(40 * 500000);
    n_fail++;
    summarize();
  end
endmodule : tb_top
